// *** vdc_params.svh ***
// register offsets, field positions, reset values and masks of the display config block
`ifndef VDC_PARAMS_SVH
`define VDC_PARAMS_SVH

`define VDC_OFS_SCALER        8'h08
`define VDC_OFS_TOP_BASE      8'h0C
`define VDC_OFS_BOT_BASE      8'h10
`define VDC_OFS_STRIDE        8'h14

`define VDC_SCALER_RESET      32'h0000_0011
`define VDC_SCALER_MASK       32'h001F_FF5F
`define VDC_BASE_RESET        32'h0FFF_FFFC
`define VDC_BASE_MASK         32'hFFFF_FFFC
`define VDC_STRIDE_RESET      32'hFFFC_0000
`define VDC_STRIDE_MASK       32'hFFFC_0000

`define VDC_BIT_DUP           20
`define VDC_POS_HDROP         14
`define VDC_POS_VDROP         8
`define VDC_BIT_SINGLE        6
`define VDC_POS_FMT           3
`define VDC_BIT_DITHER        2
`define VDC_BIT_PACK          1
`define VDC_BIT_LOW_FIRST     0
`define VDC_POS_STRIDE        16
`define VDC_BIT_OVF           8
`define VDC_BIT_GRAB_MODE     1
`define VDC_BIT_GRAB_CMD      0

`define VDC_DECIM_GROUP       7'd64
`define VDC_BOTTOM_PHASE      7'd32

`endif

// *** vdc_pkg.sv ***
// types shared by the display config block
package vdc_pkg;

    // pixel output formats
    typedef enum logic [1:0] {
        VDC_FMT_YUV422 = 2'b00,
        VDC_FMT_RGB888 = 2'b01,
        VDC_FMT_RGB565 = 2'b10,
        VDC_FMT_RGB555 = 2'b11
    } vdc_fmt_t;

    // single-frame grab sequencer
    typedef enum logic [1:0] {
        VDC_GRAB_IDLE,
        VDC_GRAB_ARMED,
        VDC_GRAB_FIELD1,
        VDC_GRAB_FIELD2
    } vdc_grab_st_t;

    // effective configuration handed to the display path
    typedef struct packed {
        logic        field_duplicate;
        logic [5:0]  horiz_drop_count;
        logic [5:0]  vert_drop_count;
        logic        single_field_select;
        vdc_fmt_t    output_format_sel;
        logic        dither_active;
        logic        rgb_pack_active;
        logic        byte_order_low_first;
        logic [31:0] top_dest_base;
        logic [31:0] bottom_dest_base;
        logic [15:0] line_increment;
    } vdc_cfg_t;

endpackage

// *** vdc_regs.sv ***
// display config registers, decimation, grab sequencer and video fifo
`timescale 1ns/1ps
`include "vdc_params.svh"

// video fifo: full/empty decoded from a registered occupancy count
module vdc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];          // storage
    logic [AW-1:0]    wr_ptr_ff;            // write index
    logic [AW-1:0]    rd_ptr_ff;            // read index
    logic [AW:0]      cnt_ff;               // occupancy
    logic [AW-1:0]    nxt_wr_ptr;
    logic [AW-1:0]    nxt_rd_ptr;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer and count next state; wrap assumes a power-of-two depth
    always_comb
    begin
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_cnt    = cnt_ff;
        if (push & ~pop)
            nxt_cnt = cnt_ff + 1'b1;
        else if (pop & ~push)
            nxt_cnt = cnt_ff - 1'b1;
    end

    // pointer and count registers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff    <= nxt_cnt;
        end
    end

    // storage has no reset, so it costs no reset tree
    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem[wr_ptr_ff] <= in_data;
    end
endmodule

// top: register file plus the small amount of logic it steers
module vdc_regs #(
    parameter int PIX_W      = 32,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // host register port
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [3:0]        reg_be,
    input  wire logic [31:0]       reg_wdata,
    output logic [31:0]            reg_rdata_ff,
    output logic                   reg_rvalid_ff,
    // enables owned by neighbouring registers
    input  wire logic              display_enable_set,
    input  wire logic              code_read_enable_set,
    input  wire logic              codec_reset_set,
    output logic                   display_enable_ff,
    output logic                   code_read_enable_ff,
    output logic                   codec_reset_ff,
    // video timing and pixel stream
    input  wire logic              field_start,
    input  wire logic              field_is_bottom,
    input  wire logic              line_start,
    input  wire logic              pix_valid,
    input  wire logic [PIX_W-1:0]  pix_data,
    // line addressing
    input  wire logic              line_done,
    input  wire logic [31:0]       last_pix_addr,
    output logic [31:0]            next_line_addr_ff,
    // pixel stream toward the bus
    output logic                   out_valid_ff,
    output logic [PIX_W-1:0]       out_data_ff,
    input  wire logic              out_ready,
    // configuration and status
    output vdc_pkg::vdc_cfg_t      cfg_ff,
    output logic                   xfer_active_ff
);
    // merge a byte-enabled write into the writable bits only
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] msk);
        logic [31:0] lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
        merge = (old & ~lanes) | (wd & lanes);
    endfunction

    // spread drops evenly: add count, drop when the sum reaches a group of 64
    function automatic logic [7:0] decim_step(input logic [6:0] acc, input logic [5:0] cnt);
        logic [6:0] sum;
        sum = acc + {1'b0, cnt};
        if (sum >= `VDC_DECIM_GROUP)
            decim_step = {1'b1, sum - `VDC_DECIM_GROUP};
        else
            decim_step = {1'b0, sum};
    endfunction

    // register storage
    logic [31:0]          scaler_pixel_format_ff;     // fields of 0x08
    logic [31:0]          top_field_base_ff;          // 0x0c
    logic [31:0]          bottom_field_base_ff;       // 0x10
    logic [31:0]          stride_ff;                  // stride bits of 0x14
    logic                 ovf_flag_ff;                // sticky overflow
    logic                 grab_mode_ff;               // grab mode
    logic                 grab_cmd_ff;                // grab command / busy
    vdc_pkg::vdc_grab_st_t grab_st_ff;                // grab sequencer
    logic [31:0]          nxt_scaler, nxt_top, nxt_bot, nxt_stride;  // register next values
    logic                 nxt_ovf, nxt_grab_mode, nxt_grab_cmd;      // status and grab next values
    vdc_pkg::vdc_grab_st_t nxt_grab_st;
    logic [31:0]          nxt_rdata;
    logic                 grab_done;                  // second field ended
    logic                 wr_scaler, wr_top, wr_bot, wr_stride;      // per-register write strobes

    // decimation and stream state
    logic [6:0]           hacc_ff;                    // horizontal phase
    logic [6:0]           vacc_ff;                    // vertical phase
    logic                 line_keep_ff;               // current line kept
    logic [6:0]           nxt_hacc;
    logic [6:0]           nxt_vacc;
    logic                 nxt_line_keep;
    logic [7:0]           hstep;
    logic [7:0]           vstep;
    logic                 keep_pix;                   // pixel survives decimation
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic [PIX_W-1:0]     fifo_out_data;
    logic                 fifo_pop;
    logic                 overflow;
    logic                 nxt_out_valid;
    logic [PIX_W-1:0]     nxt_out_data;
    logic                 nxt_xfer;
    vdc_pkg::vdc_cfg_t    nxt_cfg;
    vdc_pkg::vdc_fmt_t    fmt;
    logic [31:0]          nxt_line_addr;

    assign wr_scaler = reg_wr & (reg_addr == `VDC_OFS_SCALER);
    assign wr_top    = reg_wr & (reg_addr == `VDC_OFS_TOP_BASE);
    assign wr_bot    = reg_wr & (reg_addr == `VDC_OFS_BOT_BASE);
    assign wr_stride = reg_wr & (reg_addr == `VDC_OFS_STRIDE);
    assign grab_done = (grab_st_ff == vdc_pkg::VDC_GRAB_FIELD2) & field_start;

    // register file and grab sequencer next state
    always_comb
    begin
        nxt_scaler    = scaler_pixel_format_ff;
        nxt_top       = top_field_base_ff;
        nxt_bot       = bottom_field_base_ff;
        nxt_stride    = stride_ff;
        nxt_grab_mode = grab_mode_ff;
        nxt_grab_cmd  = grab_cmd_ff;
        nxt_grab_st   = grab_st_ff;
        nxt_ovf       = ovf_flag_ff;
        if (wr_scaler)
            nxt_scaler = merge(scaler_pixel_format_ff, reg_wdata, reg_be, `VDC_SCALER_MASK);
        if (wr_top)
            nxt_top = merge(top_field_base_ff, reg_wdata, reg_be, `VDC_BASE_MASK);
        if (wr_bot)
            nxt_bot = merge(bottom_field_base_ff, reg_wdata, reg_be, `VDC_BASE_MASK);
        if (wr_stride)
        begin
            nxt_stride = merge(stride_ff, reg_wdata, reg_be, `VDC_STRIDE_MASK);
            if (reg_be[0])
                nxt_grab_mode = reg_wdata[`VDC_BIT_GRAB_MODE];
            if (reg_be[1] & reg_wdata[`VDC_BIT_OVF])
                nxt_ovf = 1'b0;
            if (reg_be[0] & reg_wdata[`VDC_BIT_GRAB_CMD] & grab_mode_ff)
                nxt_grab_cmd = 1'b1;
        end
        // a fresh overflow beats the clearing write
        if (overflow)
            nxt_ovf = 1'b1;
        // grab sequencer: arm, wait for field edge, take two fields
        case (grab_st_ff)
            vdc_pkg::VDC_GRAB_IDLE:
                if (grab_cmd_ff)
                    nxt_grab_st = vdc_pkg::VDC_GRAB_ARMED;
            vdc_pkg::VDC_GRAB_ARMED:
                if (field_start)
                    nxt_grab_st = vdc_pkg::VDC_GRAB_FIELD1;
            vdc_pkg::VDC_GRAB_FIELD1:
                if (field_start)
                    nxt_grab_st = vdc_pkg::VDC_GRAB_FIELD2;
            vdc_pkg::VDC_GRAB_FIELD2:
                if (field_start)
                    nxt_grab_st = vdc_pkg::VDC_GRAB_IDLE;
            default:
                nxt_grab_st = vdc_pkg::VDC_GRAB_IDLE;
        endcase
        // completion clear is applied after the host set so it beats it
        if (grab_done)
            nxt_grab_cmd = 1'b0;
        // leaving grab mode abandons any grab in progress
        if (!grab_mode_ff)
        begin
            nxt_grab_st  = vdc_pkg::VDC_GRAB_IDLE;
            nxt_grab_cmd = 1'b0;
        end
        // read mux; unmapped offsets and reserved bits read zero
        case (reg_addr)
            `VDC_OFS_SCALER:   nxt_rdata = scaler_pixel_format_ff;
            `VDC_OFS_TOP_BASE: nxt_rdata = top_field_base_ff;
            `VDC_OFS_BOT_BASE: nxt_rdata = bottom_field_base_ff;
            `VDC_OFS_STRIDE:   nxt_rdata = stride_ff | {23'b0, ovf_flag_ff, 6'b0,
                                                         grab_mode_ff, grab_cmd_ff};
            default:           nxt_rdata = 32'h0000_0000;
        endcase
    end

    // register file and grab sequencer registers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scaler_pixel_format_ff <= `VDC_SCALER_RESET;
            top_field_base_ff      <= `VDC_BASE_RESET;
            bottom_field_base_ff   <= `VDC_BASE_RESET;
            stride_ff              <= `VDC_STRIDE_RESET;
            ovf_flag_ff            <= 1'b0;
            grab_mode_ff           <= 1'b0;
            grab_cmd_ff            <= 1'b0;
            grab_st_ff             <= vdc_pkg::VDC_GRAB_IDLE;
            reg_rdata_ff           <= 32'h0000_0000;
            reg_rvalid_ff          <= 1'b0;
            display_enable_ff      <= 1'b0;
            code_read_enable_ff    <= 1'b0;
            codec_reset_ff         <= 1'b1;
        end
        else
        begin
            scaler_pixel_format_ff <= nxt_scaler;
            top_field_base_ff      <= nxt_top;
            bottom_field_base_ff   <= nxt_bot;
            stride_ff              <= nxt_stride;
            ovf_flag_ff            <= nxt_ovf;
            grab_mode_ff           <= nxt_grab_mode;
            grab_cmd_ff            <= nxt_grab_cmd;
            grab_st_ff             <= nxt_grab_st;
            reg_rdata_ff           <= nxt_rdata;
            reg_rvalid_ff          <= reg_rd;
            display_enable_ff      <= display_enable_set;
            code_read_enable_ff    <= code_read_enable_set;
            codec_reset_ff         <= codec_reset_set;
        end
    end

    assign fmt   = vdc_pkg::vdc_fmt_t'(scaler_pixel_format_ff[`VDC_POS_FMT +: 2]);
    assign hstep = decim_step(hacc_ff, scaler_pixel_format_ff[`VDC_POS_HDROP +: 6]);
    assign vstep = decim_step(vacc_ff, scaler_pixel_format_ff[`VDC_POS_VDROP +: 6]);
    assign keep_pix = pix_valid & line_keep_ff & xfer_active_ff & ~hstep[7];
    assign overflow = keep_pix & ~fifo_in_ready;
    assign fifo_pop = fifo_out_valid & (~out_valid_ff | out_ready);

    // decimation, effective config, output stage and line address next state
    always_comb
    begin
        nxt_hacc      = hacc_ff;
        nxt_vacc      = vacc_ff;
        nxt_line_keep = line_keep_ff;
        if (line_start)
        begin
            nxt_hacc      = 7'd0;
            nxt_vacc      = vstep[6:0];
            nxt_line_keep = ~vstep[7];
        end
        else if (pix_valid)
            nxt_hacc = hstep[6:0];
        // interlaced source: bottom field phase offset, duplicated fields share phase
        if (field_start)
        begin
            nxt_line_keep = 1'b1;
            if (!scaler_pixel_format_ff[`VDC_BIT_DUP] && field_is_bottom)
                nxt_vacc = `VDC_BOTTOM_PHASE;
            else
                nxt_vacc = 7'd0;
        end
        // grab mode moves video only inside the two grabbed fields
        nxt_xfer = grab_mode_ff ? (grab_st_ff == vdc_pkg::VDC_GRAB_FIELD1 ||
                                   grab_st_ff == vdc_pkg::VDC_GRAB_FIELD2)
                                : display_enable_ff;
        nxt_cfg.field_duplicate      = scaler_pixel_format_ff[`VDC_BIT_DUP];
        nxt_cfg.horiz_drop_count     = scaler_pixel_format_ff[`VDC_POS_HDROP +: 6];
        nxt_cfg.vert_drop_count      = scaler_pixel_format_ff[`VDC_POS_VDROP +: 6];
        nxt_cfg.single_field_select  = scaler_pixel_format_ff[`VDC_BIT_SINGLE];
        nxt_cfg.output_format_sel    = fmt;
        nxt_cfg.dither_active        = scaler_pixel_format_ff[`VDC_BIT_DITHER] &
                                       (fmt == vdc_pkg::VDC_FMT_RGB565 ||
                                        fmt == vdc_pkg::VDC_FMT_RGB555);
        nxt_cfg.rgb_pack_active      = scaler_pixel_format_ff[`VDC_BIT_PACK] &
                                       (fmt == vdc_pkg::VDC_FMT_RGB888);
        nxt_cfg.byte_order_low_first = scaler_pixel_format_ff[`VDC_BIT_LOW_FIRST];
        nxt_cfg.top_dest_base        = top_field_base_ff;
        nxt_cfg.bottom_dest_base     = bottom_field_base_ff;
        nxt_cfg.line_increment       = stride_ff[`VDC_POS_STRIDE +: 16];
        // one-deep output register keeps the port straight from a flop
        nxt_out_valid = out_valid_ff & ~out_ready;
        nxt_out_data  = out_data_ff;
        if (fifo_pop)
        begin
            nxt_out_valid = 1'b1;
            nxt_out_data  = fifo_out_data;
        end
        nxt_line_addr = next_line_addr_ff;
        if (line_done)
            nxt_line_addr = last_pix_addr + {16'h0000, stride_ff[`VDC_POS_STRIDE +: 16]};
    end

    // decimation, config and output stage registers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hacc_ff           <= 7'd0;
            vacc_ff           <= 7'd0;
            line_keep_ff      <= 1'b1;
            xfer_active_ff    <= 1'b0;
            cfg_ff            <= '0;
            out_valid_ff      <= 1'b0;
            out_data_ff       <= '0;
            next_line_addr_ff <= 32'h0000_0000;
        end
        else
        begin
            hacc_ff           <= nxt_hacc;
            vacc_ff           <= nxt_vacc;
            line_keep_ff      <= nxt_line_keep;
            xfer_active_ff    <= nxt_xfer;
            cfg_ff            <= nxt_cfg;
            out_valid_ff      <= nxt_out_valid;
            out_data_ff       <= nxt_out_data;
            next_line_addr_ff <= nxt_line_addr;
        end
    end

    // kept pixels are buffered; a full fifo drops the pixel and raises overflow
    vdc_fifo #(
        .WIDTH (PIX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_video_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (keep_pix),
        .in_data   (pix_data),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (~out_valid_ff | out_ready)
    );
endmodule

// *** vdc_mem_sink.sv ***
// memory-side sink that takes pixel words from the display path
`timescale 1ns/1ps
module vdc_mem_sink (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // pacing from the bench
    input  wire logic hold,
    input  wire logic slow,
    // stream handshake
    output logic      out_ready
);
    logic [1:0] cnt_ff; // pacing phase, slow mode takes one word in four cycles
    // free-running phase counter
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b)
            cnt_ff <= 2'h0;
        else
            cnt_ff <= cnt_ff + 2'h1;
    // ready never looks at valid, so no loop back into the block
    assign out_ready = !hold && (!slow || cnt_ff == 2'h0);
endmodule

// *** vdc_regs_properties.sv ***
// concurrent checks on the display config register block ports
`timescale 1ns/1ps
`include "vdc_params.svh"
module vdc_regs_properties #(
    parameter int PIX_W = 32
) (
    // clock, reset and register port
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic [31:0]       reg_rdata_ff,
    // enables seen after reset
    input wire logic              display_enable_ff,
    input wire logic              code_read_enable_ff,
    input wire logic              codec_reset_ff,
    // line address and stream
    input wire logic              line_done,
    input wire logic [31:0]       last_pix_addr,
    input wire logic [31:0]       next_line_addr_ff,
    input wire logic              out_valid_ff,
    input wire logic [PIX_W-1:0]  out_data_ff,
    input wire logic              out_ready,
    input wire vdc_pkg::vdc_cfg_t cfg_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_unmapped;
        reg_rd && !(reg_addr inside {8'h08, 8'h0C, 8'h10, 8'h14}) |=> reg_rdata_ff == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_base_low;
        reg_rd && reg_addr inside {8'h0C, 8'h10} |=> reg_rdata_ff[1:0] == 2'h0;
    endproperty
    a_base_low: assert property (p_base_low) else $error("base low bits not zero");
    property p_scal_rsvd;
        reg_rd && reg_addr == 8'h08 |=> (reg_rdata_ff & ~`VDC_SCALER_MASK) == 32'h0;
    endproperty
    a_scal_rsvd: assert property (p_scal_rsvd) else $error("scaler reserved bits set");
    property p_line_addr;
        line_done && !$past(reg_wr && reg_addr == 8'h14) |=> next_line_addr_ff ==
            $past(last_pix_addr) + {16'h0, $past(cfg_ff.line_increment)};
    endproperty
    a_line_addr: assert property (p_line_addr) else $error("next line address wrong");
    // reset state is seen at the first edge after release
    property p_reset_state;
        $rose(rst_b) |-> codec_reset_ff && !display_enable_ff && !code_read_enable_ff;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("enables wrong after reset");
    property p_fmt;
        reg_wr && reg_addr == 8'h08 |=> ##1
            cfg_ff.output_format_sel == $past(reg_wdata[4:3], 2);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format select not applied");
    property p_pack;
        cfg_ff.rgb_pack_active |-> cfg_ff.output_format_sel == vdc_pkg::VDC_FMT_RGB888;
    endproperty
    a_pack: assert property (p_pack) else $error("packing outside 888");
    property p_dither;
        cfg_ff.dither_active |-> cfg_ff.output_format_sel inside {vdc_pkg::VDC_FMT_RGB565,
                                                                  vdc_pkg::VDC_FMT_RGB555};
    endproperty
    a_dither: assert property (p_dither) else $error("dither outside 565 or 555");
    // a stalled word must not vanish or change, else it is lost silently
    property p_hold;
        out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_data_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled pixel dropped");
    c_read: cover property (reg_rd ##1 reg_rdata_ff != 32'h0);
    c_line: cover property (line_done);
    c_stall: cover property (out_valid_ff && !out_ready);
endmodule
bind vdc_regs vdc_regs_properties #(.PIX_W(PIX_W)) chk (.ref_clk, .rst_b, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata_ff, .display_enable_ff, .code_read_enable_ff,
    .codec_reset_ff, .line_done, .last_pix_addr, .next_line_addr_ff, .out_valid_ff,
    .out_data_ff, .out_ready, .cfg_ff);

// *** vdc_regs_tb.sv ***
// self-checking bench for the display config register block
`timescale 1ns/1ps
module vdc_regs_tb;
    logic        ref_clk, rst_b, reg_wr, reg_rd, display_enable_set, field_start, line_start;
    logic        field_is_bottom, pix_valid, line_done, out_valid_ff, out_ready, reg_rvalid_ff;
    logic        hold, slow, ign, ow, xfer;            // sink pacing, skip, pixel on write, xfer
    logic [7:0]  reg_addr;
    logic [3:0]  reg_be;
    logic [31:0] reg_wdata, reg_rdata_ff, pix_data, last_pix_addr, next_line_addr_ff;
    logic [31:0] out_data_ff, seed, d;
    logic [31:0] rq[$], pq[$];                         // expected read data and pixels
    logic [7:0]  ra[6] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h00, 8'h18};
    logic [31:0] re[6] = '{32'h0000_0011, 32'h0FFF_FFFC, 32'h0FFF_FFFC, 32'hFFFC_0000, 0, 0};
    vdc_pkg::vdc_cfg_t cfg_ff;
    int          fails, n_checks;
    vdc_regs uut (.ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_be, .reg_wdata,
        .reg_rdata_ff, .reg_rvalid_ff, .display_enable_set, .code_read_enable_set(1'b1),
        .codec_reset_set(1'b0), .display_enable_ff(), .code_read_enable_ff(), .codec_reset_ff(),
        .field_start, .field_is_bottom, .line_start, .pix_valid, .pix_data, .line_done,
        .last_pix_addr, .next_line_addr_ff, .out_valid_ff, .out_data_ff, .out_ready, .cfg_ff,
        .xfer_active_ff(xfer));
    vdc_mem_sink mem (.ref_clk, .rst_b, .hold, .slow, .out_ready);
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // xorshift source for data and addresses
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one-cycle write; ow puts a pixel on the same edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_be, reg_wdata, pix_valid} <= {1'b1, a, be, v, ow};
        @(posedge ref_clk);
        {reg_wr, pix_valid} <= 2'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        rq.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    // k: 0 field boundary, 1 line start, 2 line done
    task automatic tick(input int k);
        @(posedge ref_clk);
        {field_start, line_start, line_done} <= {k == 0, k == 1, k == 2};
        field_is_bottom <= ~field_is_bottom;
        @(posedge ref_clk);
        {field_start, line_start, line_done} <= 3'h0;
    endtask
    task automatic pix(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            {pix_valid, pix_data} <= {1'b1, xs()};
            if (!ign)
                pq.push_back(seed);
        end
        @(posedge ref_clk);
        pix_valid <= 1'b0;
    endtask
    // bounded wait until expected pixels arrive and the stream is idle
    task automatic drain();
        int k;
        for (k = 0; k < 500 && (pq.size() != 0 || out_valid_ff !== 1'b0); k++)
            @(posedge ref_clk);
        if (k == 500)
        begin
            fails++;
            conclude();
        end
    endtask
    // monitor: settled outputs are compared at the falling edge
    always @(negedge ref_clk)
    begin
        if (reg_rvalid_ff === 1'b1)
            chk("rdata", reg_rdata_ff, rq.pop_front());
        if (out_valid_ff === 1'b1 && out_ready && !ign)
            chk("pixel", out_data_ff, pq.pop_front());
    end
    initial
    begin
        seed = 32'h0000_bfa7;
        {rst_b, reg_wr, reg_rd, display_enable_set, field_start, line_start} = 6'h0;
        {field_is_bottom, pix_valid, line_done, hold, slow, ign, ow} = 7'h0;
        {reg_addr, reg_be, reg_wdata, pix_data, last_pix_addr} = '0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        foreach (ra[i]) rd(ra[i], re[i]);
        for (int i = 0; i < 4; i++)
        begin
            d = (i == 0) ? 32'hFFFF_FFFF : xs();
            foreach (ra[j]) wr(ra[j] == 8'h14 ? 8'h1C : ra[j], d, 4'hF);
            rd(8'h08, d & `VDC_SCALER_MASK);
            rd(8'h0C, d & `VDC_BASE_MASK);
            rd(8'h10, d & `VDC_BASE_MASK);
            rd(8'h00, 32'h0);
        end
        for (int f = 0; f < 4; f++)
        begin
            wr(8'h08, {27'h0, f[1:0], 3'h6}, 4'hF);
            repeat (2) @(negedge ref_clk);
            chk("fmt", {30'h0, cfg_ff.output_format_sel}, f);
            chk("dither", {31'h0, cfg_ff.dither_active}, {31'h0, f[1]});
            chk("pack", {31'h0, cfg_ff.rgb_pack_active}, {31'h0, f == 1});
        end
        wr(8'h08, 32'h0000_0011, 4'hF);
        wr(8'h14, 32'hFFFF_FFFE, 4'hF);
        rd(8'h14, 32'hFFFC_0002);
        d = xs() & `VDC_STRIDE_MASK;
        wr(8'h14, d, 4'hF);
        repeat (2)
        begin
            last_pix_addr <= xs();
            tick(2);
            @(negedge ref_clk);
            chk("next", next_line_addr_ff, last_pix_addr + {16'h0, d[31:16]});
            @(posedge ref_clk);
        end
        display_enable_set <= 1'b1;
        slow <= 1'b1;
        tick(0);
        tick(1);
        pix(6);
        drain();
        {hold, ign} <= 2'h3;
        pix(12);
        rd(8'h14, d | 32'h100);
        ow <= 1'b1;
        wr(8'h14, 32'h100, 4'h2);
        ow <= 1'b0;
        rd(8'h14, d | 32'h100);
        wr(8'h14, 32'h100, 4'h2);
        rd(8'h14, d);
        hold <= 1'b0;
        drain();
        ign <= 1'b0;
        wr(8'h14, d | 32'h2, 4'hF);
        wr(8'h14, d | 32'h3, 4'hF);
        tick(0);
        tick(0);
        rd(8'h14, d | 32'h3);
        @(negedge ref_clk);
        chk("xfer", {31'h0, xfer}, 32'h1);
        fork
            tick(0);
            wr(8'h14, d | 32'h3, 4'hF);
        join
        rd(8'h14, d | 32'h2);
        @(negedge ref_clk);
        chk("xfer", {31'h0, xfer}, 32'h0);
        conclude();
    end
endmodule
